// *** rsc_pkg.sv ***
package rsc_pkg;

  // ****************************************************************
  // Command bytes
  // ****************************************************************
  localparam logic [7:0] CMD_RW_MASK        = 8'he0;
  localparam logic [7:0] CMD_ACK_MASK       = 8'hf8;
  localparam logic [7:0] CMD_REG_READ       = 8'h00;
  localparam logic [7:0] CMD_REG_WRITE      = 8'h20;
  localparam logic [7:0] CMD_RX_WIDTH_READ  = 8'h60;
  localparam logic [7:0] CMD_RX_READ        = 8'h61;
  localparam logic [7:0] CMD_TX_WRITE       = 8'ha0;
  localparam logic [7:0] CMD_ACK_WRITE      = 8'ha8;
  localparam logic [7:0] CMD_TX_NOACK_WRITE = 8'hb0;
  localparam logic [7:0] CMD_FLUSH_TX       = 8'he1;
  localparam logic [7:0] CMD_FLUSH_RX       = 8'he2;
  localparam logic [7:0] CMD_PAYLOAD_REUSE  = 8'he3;
  localparam logic [7:0] CMD_NOP            = 8'hff;

  // ****************************************************************
  // Register addresses and reset values
  // ****************************************************************
  localparam logic [4:0] ADDR_RADIO_CONFIG    = 5'h00;
  localparam logic [4:0] ADDR_AUTO_ACK_ENABLE = 5'h01;
  localparam logic [4:0] ADDR_RETRY_SETUP     = 5'h04;
  localparam logic [4:0] ADDR_STATUS          = 5'h07;
  localparam logic [4:0] ADDR_RETRY_OBSERVE   = 5'h08;
  localparam logic [7:0] RADIO_CONFIG_RST     = 8'h08;
  localparam logic [7:0] RADIO_CONFIG_WMASK   = 8'h7f;
  localparam logic [5:0] AUTO_ACK_RST         = 6'h3f;
  localparam logic [3:0] RETRY_LIMIT_RST      = 4'h3;
  localparam logic [2:0] PIPE_EMPTY           = 3'h7;
  localparam logic [2:0] MAX_ACK_PIPE         = 3'h5;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CFG_MASK_RX = 6;
  localparam int CFG_MASK_TX = 5;
  localparam int CFG_MASK_RL = 4;
  localparam int CFG_CRC_EN  = 3;
  localparam int CFG_CRC_LEN = 2;
  localparam int CFG_PWR     = 1;
  localparam int CFG_PRX     = 0;
  localparam int STAT_RX     = 6;
  localparam int STAT_TX     = 5;
  localparam int STAT_RL     = 4;

endpackage : rsc_pkg

// *** rsc_spi_radio.sv ***
`timescale 1ns/1ns

// How it works
// R1: retry overflow sets flag, payload stays queued
// R2: CE toggle restarts same packet; flush discards
// R3: active-low interrupt pin, three maskable sources
// R4: chip enable is active high
// R5: host starts each command with CS fall
// R6: status byte shifts out during command byte
// R7: command MSB first; data LSByte first
// R8: register read, five-bit address, LSByte first
// R9: register writes only in standby or power-down; STATUS writes still clear flags in any mode
// R10: RX payload read, deleted after read
// R11: TX payload write always starts at byte 0
// R12: flush commands empty TX or RX FIFO
// R13: reuse resends last payload until write/flush
// R14: width read returns head payload length
// R15: ack payload write, pipe 0..5, FIFO order
// R16: no-ack write disables ack for packet
// R17: all-ones command only returns status
// R18: early CS leaves unwritten bytes unchanged
// R19: status pipe number loads on interrupt fall
// R20: three-deep 32-byte TX and RX FIFOs
// R21: flags write-one-clear, masks high disable
// R22: CRC forced on by auto-ack; length select
// R23: status flags, pipe all-ones means empty
// R24: SPI mode 0, sample rise, shift fall
module rsc_spi_radio #(
  parameter int FIFO_DEPTH = 3,
  parameter int MAX_PLD    = 32
) (
  input  wire logic                       ref_clk,
  input  wire logic                       srst,
  input  wire logic                       sck,
  input  wire logic                       spi_cs_n,
  input  wire logic                       spi_mosi,
  output logic                            spi_miso,
  input  wire logic                       ce_pin,
  output logic                            irq_n,
  input  wire logic                       radio_tx_done,
  input  wire logic                       radio_tx_fail,
  input  wire logic [$clog2(MAX_PLD)-1:0] radio_tx_rd_idx,
  input  wire logic                       radio_rx_valid,
  input  wire logic [7:0]                 radio_rx_data,
  input  wire logic                       radio_rx_last,
  input  wire logic [2:0]                 radio_rx_pipe,
  output logic                            radio_tx_start,
  output logic                            radio_tx_valid,
  output logic [$clog2(MAX_PLD+1)-1:0]    radio_tx_len,
  output logic                            radio_tx_noack,
  output logic [2:0]                      radio_tx_pipe,
  output logic [7:0]                      radio_tx_rd_data,
  output logic                            radio_rx_ready,
  output logic                            radio_ce,
  output logic                            radio_crc_en,
  output logic                            radio_crc_two,
  output logic                            radio_power_up,
  output logic                            radio_rx_mode,
  output logic [5:0]                      radio_auto_ack
);
  import rsc_pkg::*;

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int IW = $clog2(MAX_PLD + 1);
  localparam int BW = $clog2(MAX_PLD);
  localparam logic [CW-1:0] FULL_CNT = CW'(FIFO_DEPTH);
  localparam logic [IW-1:0] PLD_LIM  = IW'(MAX_PLD);

  typedef struct packed {
    logic                                   cs_m, cs_s, tg_m, tg_s, tg_seen;
    logic                                   ce_m, ce_s, ce_prev;
    logic                                   have_cmd, wr_ok;
    logic [7:0]                             cmd;
    logic [IW-1:0]                          idx;
    logic [7:0]                             pub;
    logic [7:0]                             cfg;
    logic [5:0]                             aa;
    logic [3:0]                             rlimit, rcount;
    logic                                   f_rx, f_tx, f_rl, reuse, irq_n;
    logic [2:0]                             pipe_st;
    logic [FIFO_DEPTH-1:0][MAX_PLD-1:0][7:0] tmem;
    logic [FIFO_DEPTH-1:0][IW-1:0]          tlen;
    logic [FIFO_DEPTH-1:0]                  tnoack;
    logic [FIFO_DEPTH-1:0][2:0]             tpipe;
    logic [PW-1:0]                          twp, trp;
    logic [CW-1:0]                          tcnt;
    logic [FIFO_DEPTH-1:0][MAX_PLD-1:0][7:0] rmem;
    logic [FIFO_DEPTH-1:0][IW-1:0]          rlen;
    logic [FIFO_DEPTH-1:0][2:0]             rpipe;
    logic [PW-1:0]                          rwp, rrp;
    logic [CW-1:0]                          rcnt;
    logic [IW-1:0]                          rfill;
    logic                                   start, room, tvalid, tnoack_h, crc_en;
    logic [IW-1:0]                          tlen_h;
    logic [2:0]                             tpipe_h;
    logic [7:0]                             trd;
  } rsc_core_t;

  // ****************************************************************
  // Link side, clocked by the host's SPI clock
  // ****************************************************************
  logic [2:0] bit_cnt_q;
  logic       first_q;
  logic [6:0] in_sh_q;
  logic [7:0] rx_byte_q;
  logic       rx_tog_q;
  logic [7:0] tx_sh_q;
  logic       miso_q;
  rsc_core_t  q;
  rsc_core_t  d;

  // Bit counter is cleared at CS rise and held at zero while CS is high, so each frame opens with a command
  always_ff @(posedge sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      bit_cnt_q <= 3'h0; // R5
      first_q   <= 1'b1;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == 3'h7) begin
        first_q <= 1'b0;
      end
    end
  end

  // Sample MOSI on the rising edge, MSB first; byte handed over by a toggle
  always_ff @(posedge sck or posedge srst) begin
    if (srst) begin
      in_sh_q   <= 7'h00;
      rx_byte_q <= 8'h00;
      rx_tog_q  <= 1'b0;
    end else begin
      in_sh_q <= {in_sh_q[5:0], spi_mosi}; // R24 R7
      if (bit_cnt_q == 3'h7) begin
        rx_byte_q <= {in_sh_q, spi_mosi};
        rx_tog_q  <= ~rx_tog_q;
      end
    end
  end

  // Shift on the falling edge. Status bit 7 is always zero, so the idle
  // value is already its first bit. The published byte is quasi-static:
  // the host must hold SCK high after each byte while the core updates it.
  always_ff @(negedge sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      tx_sh_q <= 8'h00;
      miso_q  <= 1'b0;
    end else if (bit_cnt_q == 3'h0 || (first_q && bit_cnt_q == 3'h1)) begin
      tx_sh_q <= q.pub; // R6
      miso_q  <= q.pub[3'h7 - bit_cnt_q];
    end else begin
      miso_q <= tx_sh_q[3'h7 - bit_cnt_q]; // R24
    end
  end

  assign spi_miso = miso_q;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(FIFO_DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : ptr_inc

  function automatic logic [7:0] status_byte(input rsc_core_t s);
    status_byte = {1'b0, s.f_rx, s.f_tx, s.f_rl, s.pipe_st, s.tcnt == FULL_CNT}; // R23
  endfunction : status_byte

  function automatic logic [7:0] read_byte(input rsc_core_t s, input logic [7:0] c,
                                           input logic [IW-1:0] i);
    logic [7:0] v;
    v = 8'h00;
    if ((c & CMD_RW_MASK) == CMD_REG_READ && i == '0) begin
      case (c[4:0]) // R8
        ADDR_RADIO_CONFIG:    v = s.cfg | {4'h0, |s.aa, 3'h0}; // R22
        ADDR_AUTO_ACK_ENABLE: v = {2'b00, s.aa};
        ADDR_RETRY_SETUP:     v = {4'h0, s.rlimit};
        ADDR_STATUS:          v = status_byte(s);
        ADDR_RETRY_OBSERVE:   v = {4'h0, s.rcount};
        default:              v = 8'h00;
      endcase
    end else if (c == CMD_RX_READ && s.rcnt != '0 && i < PLD_LIM) begin
      v = s.rmem[s.rrp][i[BW-1:0]]; // R10
    end else if (c == CMD_RX_WIDTH_READ && i == '0 && s.rcnt != '0) begin
      v = 8'(s.rlen[s.rrp]); // R14
    end
    return v;
  endfunction : read_byte

  // ****************************************************************
  // Core, clocked by ref_clk
  // ****************************************************************
  logic       ev, frame_end, wr_allowed, ce_rise, is_tx_cmd;
  logic       tpush, tpop, tflush, rpush, rpop, rflush;
  logic       set_rx, set_tx, set_rl;
  logic [2:0] clr;
  logic [7:0] stat_w;

  assign stat_w = status_byte(q);

  // Next state: pin syncs, command engine, FIFOs, flags and interrupt
  always_comb begin
    d          = q;
    tpush      = 1'b0;
    tpop       = 1'b0;
    tflush     = 1'b0;
    rpush      = 1'b0;
    rpop       = 1'b0;
    rflush     = 1'b0;
    set_rx     = 1'b0;
    set_tx     = 1'b0;
    set_rl     = 1'b0;
    clr        = 3'h0;
    d.cs_m     = spi_cs_n;
    d.cs_s     = q.cs_m;
    d.tg_m     = rx_tog_q;
    d.tg_s     = q.tg_m;
    d.tg_seen  = q.tg_s;
    d.ce_m     = ce_pin;
    d.ce_s     = q.ce_m;
    d.ce_prev  = q.ce_s;
    ev         = q.tg_s != q.tg_seen;
    wr_allowed = !(q.cfg[CFG_PWR] && q.ce_s); // R9
    ce_rise    = q.ce_s && !q.ce_prev; // R4
    is_tx_cmd  = rx_byte_q == CMD_TX_WRITE || rx_byte_q == CMD_TX_NOACK_WRITE ||
                 ((rx_byte_q & CMD_ACK_MASK) == CMD_ACK_WRITE &&
                  rx_byte_q[2:0] <= MAX_ACK_PIPE); // R15
    if (ev && !q.have_cmd) begin
      d.have_cmd = 1'b1;
      d.cmd      = rx_byte_q;
      d.idx      = '0;
      d.wr_ok    = is_tx_cmd && q.tcnt != FULL_CNT; // R20
      tflush     = rx_byte_q == CMD_FLUSH_TX; // R12
      rflush     = rx_byte_q == CMD_FLUSH_RX; // R12
      if (rx_byte_q == CMD_PAYLOAD_REUSE) begin
        d.reuse = 1'b1; // R13
      end
      d.pub = read_byte(q, rx_byte_q, '0); // R17
    end else if (ev) begin
      // Each byte lands as it arrives, so an early CS keeps higher bytes
      if ((q.cmd & CMD_RW_MASK) == CMD_REG_WRITE && q.idx == '0) begin
        case (q.cmd[4:0]) // R18
          ADDR_RADIO_CONFIG:    if (wr_allowed) d.cfg = rx_byte_q & RADIO_CONFIG_WMASK;
          ADDR_AUTO_ACK_ENABLE: if (wr_allowed) d.aa = rx_byte_q[5:0];
          ADDR_RETRY_SETUP:     if (wr_allowed) d.rlimit = rx_byte_q[3:0];
          ADDR_STATUS:          clr = rx_byte_q[STAT_RX:STAT_RL]; // R21
          default:              clr = 3'h0;
        endcase
      end
      if (q.wr_ok && q.idx < PLD_LIM) begin
        d.tmem[q.twp][q.idx[BW-1:0]] = rx_byte_q; // R11
        d.tlen[q.twp]                = IW'(q.idx + 1'b1);
      end
      if (q.idx != '1) begin
        d.idx = IW'(q.idx + 1'b1);
      end
      d.pub = read_byte(q, q.cmd, IW'(q.idx + 1'b1));
    end
    // CS rise commits a payload write or retires a payload read
    frame_end = q.cs_s && q.have_cmd;
    if (frame_end) begin
      d.have_cmd = 1'b0;
      tpush      = q.wr_ok && d.idx != '0;
      rpop       = q.cmd == CMD_RX_READ && d.idx != '0 && q.rcnt != '0; // R10
    end
    if (!d.have_cmd) begin
      d.pub = stat_w; // R6
    end
    if (tpush) begin
      d.tnoack[q.twp] = q.cmd == CMD_TX_NOACK_WRITE; // R16
      d.tpipe[q.twp]  = q.cmd[2:0]; // R15
      if ((q.cmd & CMD_ACK_MASK) != CMD_ACK_WRITE) begin
        d.reuse = 1'b0; // R13
      end
    end
    // Radio engine events
    d.start = ce_rise && q.cfg[CFG_PWR] && !q.cfg[CFG_PRX] && q.tcnt != '0; // R2
    if (d.start) begin
      d.rcount = 4'h0;
    end
    if (radio_tx_fail) begin
      if (q.rcount != 4'hf) begin
        d.rcount = q.rcount + 4'h1;
      end
      set_rl = q.rcount >= q.rlimit; // R1
    end
    if (radio_tx_done) begin
      set_tx = 1'b1;
      tpop   = !q.reuse && q.tcnt != '0; // R13
    end
    if (radio_rx_valid && q.rcnt != FULL_CNT) begin
      if (q.rfill < PLD_LIM) begin
        d.rmem[q.rwp][q.rfill[BW-1:0]] = radio_rx_data;
      end
      if (radio_rx_last) begin
        d.rlen[q.rwp]  = IW'(q.rfill + 1'b1);
        d.rpipe[q.rwp] = radio_rx_pipe;
        d.rfill        = '0;
        rpush          = 1'b1;
        set_rx         = 1'b1; // R23
      end else if (q.rfill != '1) begin
        d.rfill = IW'(q.rfill + 1'b1);
      end
    end
    // Flush wins over push and pop of the same cycle
    if (tflush) begin
      d.tcnt  = '0; // R12
      d.twp   = '0;
      d.trp   = '0;
      d.reuse = 1'b0;
    end else begin
      d.twp  = tpush ? ptr_inc(q.twp) : q.twp;
      d.trp  = tpop ? ptr_inc(q.trp) : q.trp;
      d.tcnt = CW'(q.tcnt + CW'(tpush) - CW'(tpop)); // R20
    end
    if (rflush) begin
      d.rcnt  = '0; // R12
      d.rwp   = '0;
      d.rrp   = '0;
      d.rfill = '0;
    end else begin
      d.rwp  = rpush ? ptr_inc(q.rwp) : q.rwp;
      d.rrp  = rpop ? ptr_inc(q.rrp) : q.rrp;
      d.rcnt = CW'(q.rcnt + CW'(rpush) - CW'(rpop));
    end
    // A set in the same cycle as its clear wins
    d.f_rx  = (q.f_rx & ~clr[2]) | set_rx; // R21
    d.f_tx  = (q.f_tx & ~clr[1]) | set_tx; // R21
    d.f_rl  = (q.f_rl & ~clr[0]) | set_rl; // R1
    d.irq_n = !((d.f_rx && !d.cfg[CFG_MASK_RX]) || (d.f_tx && !d.cfg[CFG_MASK_TX]) ||
                (d.f_rl && !d.cfg[CFG_MASK_RL])); // R3 R21
    // Pipe number only moves on the interrupt falling edge or when empty
    if (q.irq_n && !d.irq_n) begin
      d.pipe_st = (d.rcnt != '0) ? d.rpipe[d.rrp] : PIPE_EMPTY; // R19
    end else if (d.rcnt == '0) begin
      d.pipe_st = PIPE_EMPTY; // R23
    end
    d.room     = d.rcnt != FULL_CNT;
    d.tvalid   = d.tcnt != '0;
    d.tlen_h   = d.tlen[d.trp];
    d.tnoack_h = d.tnoack[d.trp];
    d.tpipe_h  = d.tpipe[d.trp];
    d.crc_en   = d.cfg[CFG_CRC_EN] | (|d.aa); // R22
    d.trd      = q.tmem[q.trp][radio_tx_rd_idx];
  end

  // State register with reset values
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q         <= '0;
      q.cs_m    <= 1'b1;
      q.cs_s    <= 1'b1;
      q.cfg     <= RADIO_CONFIG_RST;
      q.aa      <= AUTO_ACK_RST;
      q.rlimit  <= RETRY_LIMIT_RST;
      q.pipe_st <= PIPE_EMPTY;
      // Published byte starts as the reset status, so the first frame is right
      q.pub     <= {4'h0, PIPE_EMPTY, 1'b0};
      q.irq_n   <= 1'b1;
      q.room    <= 1'b1;
      q.crc_en  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs, each straight from a state flop
  assign irq_n            = q.irq_n;
  assign radio_tx_start   = q.start;
  assign radio_tx_valid   = q.tvalid;
  assign radio_tx_len     = q.tlen_h;
  assign radio_tx_noack   = q.tnoack_h;
  assign radio_tx_pipe    = q.tpipe_h;
  assign radio_tx_rd_data = q.trd;
  assign radio_rx_ready   = q.room;
  assign radio_ce         = q.ce_s;
  assign radio_crc_en     = q.crc_en;
  assign radio_crc_two    = q.cfg[CFG_CRC_LEN]; // R22
  assign radio_power_up   = q.cfg[CFG_PWR];
  assign radio_rx_mode    = q.cfg[CFG_PRX];
  assign radio_auto_ack   = q.aa;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  sequence s_ce_rise;
    !q.ce_s ##1 q.ce_s;
  endsequence

  property p_irq_level;
    (q.f_rx && !q.cfg[CFG_MASK_RX]) || (q.f_tx && !q.cfg[CFG_MASK_TX]) ||
      (q.f_rl && !q.cfg[CFG_MASK_RL]) |-> !irq_n;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not low"); // R3

  property p_mask_all;
    (&q.cfg[CFG_MASK_RX:CFG_MASK_RL]) |-> irq_n;
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("masked irq"); // R21

  property p_set_wins;
    set_tx && clr[1] |=> q.f_tx;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost"); // R21

  property p_retry_keep;
    set_rl && !tpush && !tflush |=> q.f_rl && q.tcnt == $past(q.tcnt);
  endproperty
  a_retry_keep: assert property (p_retry_keep) else $error("payload lost"); // R1

  property p_ce_restart;
    s_ce_rise ##0 (q.cfg[CFG_PWR] && !q.cfg[CFG_PRX] && q.tcnt != '0)
      |=> radio_tx_start ##1 !radio_tx_start;
  endproperty
  a_ce_restart: assert property (p_ce_restart) else $error("no restart"); // R2

  property p_flush_tx;
    tflush |=> q.tcnt == '0 && !radio_tx_valid;
  endproperty
  a_flush_tx: assert property (p_flush_tx) else $error("tx not flushed"); // R12

  property p_write_blocked;
    ev && q.have_cmd && q.cmd == (CMD_REG_WRITE | {3'h0, ADDR_RADIO_CONFIG}) &&
      !wr_allowed |=> $stable(q.cfg);
  endproperty
  a_write_blocked: assert property (p_write_blocked) else $error("cfg written"); // R9

  property p_rx_delete;
    rpop && !rpush && !rflush |=> q.rcnt == $past(q.rcnt) - 1;
  endproperty
  a_rx_delete: assert property (p_rx_delete) else $error("rx not deleted"); // R10

  property p_pipe_empty;
    q.rcnt == '0 |-> q.pipe_st == PIPE_EMPTY;
  endproperty
  a_pipe_empty: assert property (p_pipe_empty) else $error("pipe not empty"); // R23

  property p_status_pub;
    !d.have_cmd |=> q.pub == $past(stat_w);
  endproperty
  a_status_pub: assert property (p_status_pub) else $error("status stale"); // R6

  property p_crc_forced;
    (|q.aa) |-> radio_crc_en;
  endproperty
  a_crc_forced: assert property (p_crc_forced) else $error("crc off"); // R22

  property p_reuse_keep;
    radio_tx_done && q.reuse && !tpush && !tflush |=> q.tcnt == $past(q.tcnt);
  endproperty
  a_reuse_keep: assert property (p_reuse_keep) else $error("reused popped"); // R13

endmodule : rsc_spi_radio

// *** rsc_host_model.sv ***
`timescale 1ns/1ns
module rsc_host_model (
  output logic     sck,
  output logic     spi_cs_n,
  output logic     spi_mosi,
  input  wire logic spi_miso
);
  logic [7:0] tx_q [0:31];
  logic [7:0] rx_q [0:32];

  // Idle: clock parked low, frame closed
  initial begin
    sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // ************
  // One frame: command then n data bytes; returned bytes land in rx_q
  // ************
  task automatic frame(input logic [7:0] cmd, input int n);
    logic [7:0] b;
    spi_cs_n = 1'b0;
    #80;
    for (int i = 0; i <= n; i++) begin
      b = (i == 0) ? cmd : tx_q[i-1];
      for (int k = 7; k >= 0; k--) begin
        spi_mosi = b[k];
        #6 sck = 1'b1;
        rx_q[i][k] = spi_miso;
        // Long high phase after each byte lets the core stage the next one
        #(k == 0 ? 80 : 6) sck = 1'b0;
      end
    end
    #80 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi; // Released line must not hold its last value
    #100;
  endtask : frame
endmodule : rsc_host_model

// *** tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  import rsc_pkg::*;
  logic       ref_clk = 1'b0;
  logic       srst = 1'b0;
  logic       ce_pin = 1'b0;
  logic       tx_fail = 1'b0;
  logic       tx_done = 1'b0;
  logic       tx_start, radio_ce, rx_ready, power_up, rx_mode;
  logic [2:0] tx_pipe;
  logic [5:0] auto_ack;
  logic [4:0] rd_idx = 5'h00;
  logic       rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic       rx_last = 1'b0;
  logic [2:0] rx_pipe = 3'h0;
  logic       sck, cs_n, mosi, miso, irq_n;
  logic       tx_valid, tx_noack, crc_en, crc_two;
  logic [5:0] tx_len;
  logic [7:0] tx_rd;
  int         fail_count = 0;
  int         checks_done = 0;

  rsc_host_model u_host (.sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso));

  rsc_spi_radio u_dut (
    .ref_clk(ref_clk), .srst(srst), .sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso(miso), .ce_pin(ce_pin), .irq_n(irq_n), .radio_tx_done(tx_done),
    .radio_tx_fail(tx_fail), .radio_tx_rd_idx(rd_idx), .radio_rx_valid(rx_valid),
    .radio_rx_data(rx_data), .radio_rx_last(rx_last), .radio_rx_pipe(rx_pipe),
    .radio_tx_start(tx_start), .radio_tx_valid(tx_valid), .radio_tx_len(tx_len),
    .radio_tx_noack(tx_noack), .radio_tx_pipe(tx_pipe), .radio_tx_rd_data(tx_rd),
    .radio_rx_ready(rx_ready), .radio_ce(radio_ce), .radio_crc_en(crc_en),
    .radio_crc_two(crc_two), .radio_power_up(power_up), .radio_rx_mode(rx_mode),
    .radio_auto_ack(auto_ack));

  // 100 MHz core clock
  always #5 ref_clk = ~ref_clk;

  // ************
  // Shared helpers
  // ************
  function automatic logic [7:0] b8(input logic b);
    return {7'h00, b};
  endfunction : b8

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  // Frame plus settling time for the core to commit it
  task automatic spi(input logic [7:0] cmd, input int n);
    u_host.frame(cmd, n);
    cyc(6);
  endtask : spi

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    u_host.tx_q[0] = v;
    spi(CMD_REG_WRITE | {3'h0, a}, 1);
  endtask : wr

  task automatic rd(input string nm, input logic [4:0] a, input logic [7:0] exp);
    spi(CMD_REG_READ | {3'h0, a}, 1);
    chk(nm, exp, u_host.rx_q[1]);
  endtask : rd

  task automatic stat(input logic [7:0] exp);
    spi(CMD_NOP, 0);
    chk("status", exp, u_host.rx_q[0]);
  endtask : stat

  // Bounded wait; running out ends the run
  task automatic wait_irq(input logic exp);
    for (int i = 0; i < 50 && irq_n !== exp; i++) cyc(1);
    chk("irq_n", b8(exp), b8(irq_n));
    if (irq_n !== exp) give_verdict();
  endtask : wait_irq

  task automatic pulse_fail();
    tx_fail <= 1'b1;
    cyc(1);
    tx_fail <= 1'b0;
    cyc(3);
  endtask : pulse_fail

  task automatic pulse_done();
    tx_done <= 1'b1;
    cyc(1);
    tx_done <= 1'b0;
    cyc(3);
  endtask : pulse_done

  task automatic push_rx(input logic [7:0] d, input logic last);
    rx_valid <= 1'b1;
    rx_data <= d;
    rx_last <= last;
    cyc(1);
    rx_valid <= 1'b0;
    cyc(1);
  endtask : push_rx

  // ************
  // Scenarios
  // ************
  task automatic t_reset();
    chk("irq_n", 8'h01, b8(irq_n));
    chk("crc_en", 8'h01, b8(crc_en));
    stat(8'h0e);
    rd("config", ADDR_RADIO_CONFIG, 8'h08);
    rd("auto_ack", ADDR_AUTO_ACK_ENABLE, 8'h3f);
    $display("test reset done");
  endtask : t_reset

  task automatic t_config();
    wr(ADDR_RADIO_CONFIG, 8'h07);
    rd("config", ADDR_RADIO_CONFIG, 8'h0f);
    chk("crc_en", 8'h01, b8(crc_en));
    chk("crc_two", 8'h01, b8(crc_two));
    chk("power_up", 8'h01, b8(power_up));
    chk("rx_mode", 8'h01, b8(rx_mode));
    wr(ADDR_AUTO_ACK_ENABLE, 8'h00);
    chk("auto_ack", 8'h00, {2'h0, auto_ack});
    chk("crc_en", 8'h00, b8(crc_en));
    ce_pin <= 1'b1;
    cyc(4);
    // Powered up and enabled: this write must be ignored
    wr(ADDR_RADIO_CONFIG, 8'h08);
    rd("config", ADDR_RADIO_CONFIG, 8'h07);
    ce_pin <= 1'b0;
    cyc(4);
    wr(ADDR_RADIO_CONFIG, 8'h08);
    wr(ADDR_AUTO_ACK_ENABLE, 8'h3f);
    rd("auto_ack", ADDR_AUTO_ACK_ENABLE, 8'h3f);
    $display("test config done");
  endtask : t_config

  task automatic t_tx();
    int n;
    u_host.tx_q[0] = 8'h11;
    u_host.tx_q[1] = 8'h22;
    spi(CMD_TX_WRITE, 2);
    chk("tx_valid", 8'h01, b8(tx_valid));
    chk("tx_len", 8'h02, {2'h0, tx_len});
    rd_idx <= 5'h01;
    cyc(3);
    chk("tx_byte1", 8'h22, tx_rd);
    repeat (3) pulse_fail();
    chk("irq_n", 8'h01, b8(irq_n));
    pulse_fail();
    wait_irq(1'b0);
    stat(8'h1e);
    rd("retry_count", ADDR_RETRY_OBSERVE, 8'h04);
    chk("tx_valid", 8'h01, b8(tx_valid));
    wr(ADDR_STATUS, 8'h10);
    wait_irq(1'b1);
    // CE rise with the packet retained must start exactly one transmission
    wr(ADDR_RADIO_CONFIG, 8'h0a);
    ce_pin <= 1'b1;
    n = 0;
    repeat (8) begin
      cyc(1);
      n += tx_start;
    end
    chk("tx_start", 8'h01, 8'(n));
    chk("radio_ce", 8'h01, b8(radio_ce));
    ce_pin <= 1'b0;
    cyc(4);
    wr(ADDR_RADIO_CONFIG, 8'h08);
    spi(CMD_PAYLOAD_REUSE, 0);
    pulse_done();
    chk("tx_valid", 8'h01, b8(tx_valid));
    stat(8'h2e);
    wr(ADDR_STATUS, 8'h20);
    spi(CMD_FLUSH_TX, 0);
    chk("tx_valid", 8'h00, b8(tx_valid));
    spi(CMD_ACK_WRITE | 8'h06, 1);
    chk("tx_valid", 8'h00, b8(tx_valid));
    spi(CMD_TX_NOACK_WRITE, 1);
    chk("tx_noack", 8'h01, b8(tx_noack));
    spi(CMD_ACK_WRITE | 8'h05, 1);
    spi(CMD_TX_WRITE, 1);
    stat(8'h0f);
    pulse_done();
    chk("tx_pipe", 8'h05, {5'h00, tx_pipe});
    wr(ADDR_STATUS, 8'h20);
    spi(CMD_FLUSH_TX, 0);
    $display("test tx done");
  endtask : t_tx

  task automatic t_rx();
    rx_pipe <= 3'h2;
    push_rx(8'haa, 1'b0);
    push_rx(8'hbb, 1'b0);
    push_rx(8'hcc, 1'b1);
    wait_irq(1'b0);
    cyc(4);
    stat(8'h44);
    spi(CMD_RX_WIDTH_READ, 1);
    chk("rx_width", 8'h03, u_host.rx_q[1]);
    wr(ADDR_RADIO_CONFIG, 8'h48);
    wait_irq(1'b1);
    wr(ADDR_RADIO_CONFIG, 8'h08);
    spi(CMD_RX_READ, 3);
    chk("rx_b0", 8'haa, u_host.rx_q[1]);
    chk("rx_b2", 8'hcc, u_host.rx_q[3]);
    stat(8'h4e);
    wr(ADDR_STATUS, 8'h40);
    wait_irq(1'b1);
    stat(8'h0e);
    repeat (3) push_rx(8'hdd, 1'b1);
    chk("rx_ready", 8'h00, b8(rx_ready));
    spi(CMD_FLUSH_RX, 0);
    chk("rx_ready", 8'h01, b8(rx_ready));
    stat(8'h4e);
    $display("test rx done");
  endtask : t_rx

  // ************
  // Main sequence and verdict
  // ************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    // Reset rises as an edge so the link-side toggle flop is cleared as well
    srst <= 1'b1;
    cyc(16);
    srst <= 1'b0;
    cyc(6);
    t_reset();
    t_config();
    t_tx();
    t_rx();
    give_verdict();
  end
endmodule : tb_top
